// ==== pafo_pad_model.sv ====
`timescale 1ns/1ps
module pafo_pad_model
(
    input  wire logic       clk,
    input  wire logic [7:0] oe,
    input  wire logic [7:0] drive,
    input  wire logic [7:0] pull_en,
    input  wire logic [7:0] ext_en,
    input  wire logic [7:0] ext_lvl,
    output logic      [7:0] pad
);
    // floating pins wander so stale levels never look valid
    logic [7:0] drift = 8'h55;
    always @(posedge clk) drift <= ~drift;
    // own driver, else far party (select low from master), else pull-up
    assign pad = (oe & drive) | (~oe & ext_en & ext_lvl)
        | (~oe & ~ext_en & (pull_en | drift));
endmodule : pafo_pad_model

// ==== pafo_pin.sv ====
`timescale 1ns/1ps
module pafo_pin
(
    input  wire pafo_pkg::pafo_override_t ovr,
    input  wire logic                     dir_bit,
    input  wire logic                     out_bit,
    input  wire logic                     global_pullup_disable,
    input  wire logic                     sleep,
    input  wire logic                     pad_in,
    output logic                          pad_oe,
    output logic                          pad_out,
    output logic                          pullup_en,
    output logic                          alt_digital_in
);
    import pafo_pkg::*;

    wire normal_pullup;
    wire selected_value;
    wire input_enable;

    // ------------------------------------------------------------
    // pull-up
    // ------------------------------------------------------------
    assign normal_pullup = ({dir_bit, out_bit, global_pullup_disable}
                            == 3'h2);                        // R2
    assign pullup_en = ovr.pullup_override_en
                     ? ovr.pullup_override_val               // R1
                     : normal_pullup;                        // R22

    // ------------------------------------------------------------
    // driver enable and level
    // ------------------------------------------------------------
    assign pad_oe = ovr.dir_override_en
                  ? ovr.dir_override_val                     // R3
                  : dir_bit;                                 // R4 R20
    assign selected_value = ovr.out_value_override_en
                          ? ovr.out_value_override_val       // R5
                          : out_bit;                         // R6
    assign pad_out = pad_oe & selected_value;                // R23

    // ------------------------------------------------------------
    // digital input clamp
    // ------------------------------------------------------------
    assign input_enable = ovr.input_enable_override_en
                        ? ovr.input_enable_override_val      // R8
                        : ~sleep;                            // R9
    assign alt_digital_in = pad_in & input_enable;           // R10

endmodule : pafo_pin

// ==== pafo_pkg.sv ====
// Behaviour
// R1: pull-up override enable selects override value only
// R2: else pull-up when dir,out,disable equal 010
// R3: direction override enable selects override value
// R4: else driver enable follows direction bit
// R5: value override with driver on drives override
// R6: else driven level follows output bit
// R7: toggle override inverts output register bit
// R8: input enable override selects override value
// R9: else digital input disabled by sleep
// R10: alternate input after clamp, before synchroniser
// R11: strobes per port; clock, sleep, disable shared
// R12: slave spi forces bit 7 input
// R13: external master drives select low for slave
// R14: slave spi forces bit 5 input
// R15: master spi forces bit 4 input
// R16: slave spi forces bit 3 input
// R17: forced inputs keep pull-up via output bit
// R18: every bit is a pin-change source
// R19: bit 2 timer clock, 1 timer3 out, 0 capture
// R20: direction one output, zero input
// R21: pin-input write of one toggles output bit
// R22: override selection purely combinational per pin
// R23: disabled driver makes output value irrelevant
package pafo_pkg;

    localparam int PORT_WIDTH = 8;

    // ------------------------------------------------------------
    // bit positions of port b alternate functions
    // ------------------------------------------------------------
    localparam int BIT_SLAVE_SEL   = 7;
    localparam int BIT_SPI_CLK     = 5;
    localparam int BIT_MISO        = 4;
    localparam int BIT_MOSI        = 3;
    localparam int BIT_TIMER_CLK   = 2;
    localparam int BIT_TIMER3_OUT  = 1;
    localparam int BIT_TIMER3_CAPT = 0;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [PORT_WIDTH-1:0] DIR_RESET  = 8'h00;
    localparam logic [PORT_WIDTH-1:0] OUT_RESET  = 8'h00;
    localparam logic [PORT_WIDTH-1:0] SYNC_RESET = 8'h00;

    // per-pin override bundle
    typedef struct packed {
        logic pullup_override_en;
        logic pullup_override_val;
        logic dir_override_en;
        logic dir_override_val;
        logic out_value_override_en;
        logic out_value_override_val;
        logic toggle_override_en;
        logic input_enable_override_en;
        logic input_enable_override_val;
    } pafo_override_t;

    // port-wide register write strobes and data
    typedef struct packed {
        logic                  port_write_strobe;
        logic                  dir_write_strobe;
        logic                  pin_write_strobe;
        logic [PORT_WIDTH-1:0] data;
    } pafo_write_t;

    // spi and timer peripheral controls
    typedef struct packed {
        logic spi_enable;
        logic spi_master;
        logic spi_clk_out;
        logic spi_slave_out;
        logic spi_master_out;
        logic timer3_out_enable;
        logic timer3_mod_out;
    } pafo_periph_t;

endpackage : pafo_pkg

// ==== pafo_port.sv ====
`timescale 1ns/1ps
module pafo_port
(
    input  wire logic                                CLOCK,
    input  wire logic                                RESET,
    input  wire logic                                SLEEP,
    input  wire logic                                GLOBAL_PULLUP_DISABLE,
    input  wire pafo_pkg::pafo_write_t               WRITE,
    input  wire pafo_pkg::pafo_periph_t              PERIPH,
    input  wire logic                                PIN_CHANGE_GROUP_EN,
    input  wire logic [pafo_pkg::PORT_WIDTH-1:0]     PIN_CHANGE_MASK,
    input  wire logic [pafo_pkg::PORT_WIDTH-1:0]     PAD_IN,
    output logic      [pafo_pkg::PORT_WIDTH-1:0]     PAD_OUT,
    output logic      [pafo_pkg::PORT_WIDTH-1:0]     PAD_OE,
    output logic      [pafo_pkg::PORT_WIDTH-1:0]     PAD_PULLUP,
    output logic      [pafo_pkg::PORT_WIDTH-1:0]     DIR_BIT,
    output logic      [pafo_pkg::PORT_WIDTH-1:0]     OUT_BIT,
    output logic      [pafo_pkg::PORT_WIDTH-1:0]     PIN_IN_BIT,
    output logic      [pafo_pkg::PORT_WIDTH-1:0]     PIN_CHANGE_SRC,
    output logic                                     SPI_SLAVE_SEL_IN,
    output logic                                     SPI_CLK_IN,
    output logic                                     SPI_MASTER_IN,
    output logic                                     SPI_SLAVE_IN,
    output logic                                     TIMER_EXT_CLK_IN,
    output logic                                     TIMER3_CAPTURE_IN
);
    import pafo_pkg::*;

    logic [PORT_WIDTH-1:0] dir_bit;
    logic [PORT_WIDTH-1:0] out_bit;
    logic [PORT_WIDTH-1:0] pin_in_bit;
    logic [PORT_WIDTH-1:0] sync_1;
    logic [PORT_WIDTH-1:0] sync_2;
    logic [PORT_WIDTH-1:0] sync_3;

    wire [PORT_WIDTH-1:0] next_dir;
    wire [PORT_WIDTH-1:0] next_out;
    wire [PORT_WIDTH-1:0] next_pin_in;
    wire [PORT_WIDTH-1:0] written_out;
    wire [PORT_WIDTH-1:0] toggle_mask;
    wire [PORT_WIDTH-1:0] toggle_ovr;
    wire [PORT_WIDTH-1:0] alt_digital_in;
    wire [PORT_WIDTH-1:0] settled;

    pafo_override_t ovr [PORT_WIDTH];

    wire spi_slave;
    wire spi_master;

    // ------------------------------------------------------------
    // spi role decode
    // ------------------------------------------------------------
    assign spi_slave  = PERIPH.spi_enable & ~PERIPH.spi_master;
    assign spi_master = PERIPH.spi_enable & PERIPH.spi_master;

    // ------------------------------------------------------------
    // per-pin override sources
    // ------------------------------------------------------------
    genvar n;
    generate
        for (n = 0; n < PORT_WIDTH; n++)
        begin : g_ovr
            wire forced_input;
            wire pull_forced;
            wire value_en;
            wire value_val;

            if (n == BIT_SLAVE_SEL || n == BIT_SPI_CLK
                || n == BIT_MOSI)
            begin : g_slave_in
                assign forced_input = spi_slave;     // R12 R14 R16
            end
            else if (n == BIT_MISO)
            begin : g_master_in
                assign forced_input = spi_master;    // R15
            end
            else
            begin : g_plain
                assign forced_input = 1'b0;
            end

            // forced inputs keep pull-up from the output bit
            assign pull_forced = out_bit[n]
                               & ~GLOBAL_PULLUP_DISABLE;     // R17

            if (n == BIT_SPI_CLK)
            begin : g_clk_out
                assign value_en  = spi_master;
                assign value_val = PERIPH.spi_clk_out;
            end
            else if (n == BIT_MISO)
            begin : g_miso_out
                assign value_en  = spi_slave;
                assign value_val = PERIPH.spi_slave_out;
            end
            else if (n == BIT_MOSI)
            begin : g_mosi_out
                assign value_en  = spi_master;
                assign value_val = PERIPH.spi_master_out;
            end
            else if (n == BIT_TIMER3_OUT)
            begin : g_timer_out
                assign value_en  = PERIPH.timer3_out_enable;  // R19
                assign value_val = PERIPH.timer3_mod_out;     // R19
            end
            else
            begin : g_no_out
                assign value_en  = 1'b0;
                assign value_val = 1'b0;
            end

            assign ovr[n].pullup_override_en        = forced_input;
            assign ovr[n].pullup_override_val       = pull_forced;
            assign ovr[n].dir_override_en           = forced_input;
            assign ovr[n].dir_override_val          = 1'b0;
            assign ovr[n].out_value_override_en     = value_en;
            assign ovr[n].out_value_override_val    = value_val;
            assign ovr[n].toggle_override_en        = 1'b0;
            // armed pin-change source keeps input alive in sleep
            assign ovr[n].input_enable_override_en  =
                PIN_CHANGE_MASK[n] & PIN_CHANGE_GROUP_EN;    // R18
            assign ovr[n].input_enable_override_val = 1'b1;

            assign toggle_ovr[n] = ovr[n].toggle_override_en;

            // shared sleep, pull-up disable; per-pin overrides
            pafo_pin u_pin
            (
                .ovr                   (ovr[n]),
                .dir_bit               (dir_bit[n]),
                .out_bit               (out_bit[n]),
                .global_pullup_disable (GLOBAL_PULLUP_DISABLE),  // R11
                .sleep                 (SLEEP),                  // R11
                .pad_in                (PAD_IN[n]),
                .pad_oe                (PAD_OE[n]),
                .pad_out               (PAD_OUT[n]),
                .pullup_en             (PAD_PULLUP[n]),
                .alt_digital_in        (alt_digital_in[n])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // port registers
    // ------------------------------------------------------------
    // strobes are port wide and act on all bits at once
    assign next_dir = WRITE.dir_write_strobe
                    ? WRITE.data : dir_bit;                  // R11 R20
    assign written_out = WRITE.port_write_strobe
                       ? WRITE.data : out_bit;               // R11
    assign toggle_mask = WRITE.pin_write_strobe
                       ? WRITE.data : '0;                    // R21
    assign next_out = written_out ^ toggle_mask
                    ^ toggle_ovr;                            // R7

    always_ff @(posedge CLOCK or posedge RESET)
    begin
        if (RESET)
        begin
            dir_bit <= DIR_RESET;
            out_bit <= OUT_RESET;
        end
        else
        begin
            dir_bit <= next_dir;
            out_bit <= next_out;
        end
    end

    // ------------------------------------------------------------
    // pin readback synchroniser
    // ------------------------------------------------------------
    // a change counts once the second and third stage agree
    assign settled     = ~(sync_2 ^ sync_3);
    assign next_pin_in = (sync_3 & settled) | (pin_in_bit & ~settled);

    always_ff @(posedge CLOCK or posedge RESET)
    begin
        if (RESET)
        begin
            sync_1     <= SYNC_RESET;
            sync_2     <= SYNC_RESET;
            sync_3     <= SYNC_RESET;
            pin_in_bit <= SYNC_RESET;
        end
        else
        begin
            sync_1     <= alt_digital_in;
            sync_2     <= sync_1;
            sync_3     <= sync_2;
            pin_in_bit <= next_pin_in;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign DIR_BIT    = dir_bit;
    assign OUT_BIT    = out_bit;
    assign PIN_IN_BIT = pin_in_bit;

    // raw clamped inputs; receivers synchronise these themselves
    assign PIN_CHANGE_SRC    = alt_digital_in;                 // R10 R18
    assign SPI_SLAVE_SEL_IN  = alt_digital_in[BIT_SLAVE_SEL];  // R13
    assign SPI_CLK_IN        = alt_digital_in[BIT_SPI_CLK];
    assign SPI_MASTER_IN     = alt_digital_in[BIT_MISO];
    assign SPI_SLAVE_IN      = alt_digital_in[BIT_MOSI];
    assign TIMER_EXT_CLK_IN  = alt_digital_in[BIT_TIMER_CLK];  // R19
    assign TIMER3_CAPTURE_IN = alt_digital_in[BIT_TIMER3_CAPT]; // R19

endmodule : pafo_port

// ==== pafo_port_asserts.sv ====
`timescale 1ns/1ps
module pafo_port_asserts
(
    input wire logic                   CLOCK,
    input wire logic                   RESET,
    input wire logic                   SLEEP,
    input wire logic                   GLOBAL_PULLUP_DISABLE,
    input wire pafo_pkg::pafo_write_t  WRITE,
    input wire pafo_pkg::pafo_periph_t PERIPH,
    input wire logic                   PIN_CHANGE_GROUP_EN,
    input wire logic [7:0]             PIN_CHANGE_MASK,
    input wire logic [7:0]             PAD_IN,
    input wire logic [7:0]             PAD_OUT,
    input wire logic [7:0]             PAD_OE,
    input wire logic [7:0]             PAD_PULLUP,
    input wire logic [7:0]             DIR_BIT,
    input wire logic [7:0]             OUT_BIT,
    input wire logic [7:0]             PIN_IN_BIT,
    input wire logic [7:0]             PIN_CHANGE_SRC,
    input wire logic                   TIMER_EXT_CLK_IN,
    input wire logic                   TIMER3_CAPTURE_IN
);
    import pafo_pkg::*;
    wire slave  = PERIPH.spi_enable & ~PERIPH.spi_master;
    wire master = PERIPH.spi_enable & PERIPH.spi_master;
    wire pu_off = GLOBAL_PULLUP_DISABLE;
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RESET);
    // awake with a pad level that holds
    sequence quiet_in;
        !SLEEP && $stable(PAD_IN);
    endsequence
    sequence settled_in;
        quiet_in [*5];
    endsequence
    norm_pullup_a: assert property (PAD_PULLUP[6] ==
        (~DIR_BIT[6] & OUT_BIT[6] & ~pu_off)) else $error("pull-up wrong");
    ovr_pullup_a: assert property (slave |->
        PAD_PULLUP[7] == (OUT_BIT[7] & ~pu_off)) else $error("forced pull-up");
    slave_dir_a: assert property (slave |->
        !PAD_OE[7] && !PAD_OE[5] && !PAD_OE[3]) else $error("slave dir");
    master_dir_a: assert property (master |->
        !PAD_OE[4] && PAD_OE[7] == DIR_BIT[7]) else $error("master dir");
    dir_follow_a: assert property (PAD_OE[6] == DIR_BIT[6])
        else $error("driver enable");
    drive_off_a: assert property ((PAD_OUT & ~PAD_OE) == 8'h00)
        else $error("undriven output");
    out_value_a: assert property (PAD_OE[6] |-> PAD_OUT[6] == OUT_BIT[6])
        else $error("output level");
    ovr_value_a: assert property (master && DIR_BIT[5] |->
        PAD_OUT[5] == PERIPH.spi_clk_out) else $error("override level");
    toggle_wr_a: assert property (WRITE.pin_write_strobe &&
        !WRITE.port_write_strobe |=> OUT_BIT == ($past(OUT_BIT)
        ^ $past(WRITE.data))) else $error("toggle write");
    sleep_clamp_a: assert property (SLEEP && !PIN_CHANGE_GROUP_EN |->
        PIN_CHANGE_SRC == 8'h00) else $error("sleep clamp");
    armed_in_a: assert property (PIN_CHANGE_GROUP_EN |->
        ((PIN_CHANGE_SRC ^ PAD_IN) & PIN_CHANGE_MASK) == 8'h00)
        else $error("armed input");
    sync_in_a: assert property (settled_in |-> PIN_IN_BIT == PAD_IN)
        else $error("readback");
    timer_map_a: assert property (TIMER_EXT_CLK_IN == PIN_CHANGE_SRC[2]
        && TIMER3_CAPTURE_IN == PIN_CHANGE_SRC[0]) else $error("timer map");
endmodule : pafo_port_asserts

bind pafo_port pafo_port_asserts i_chk (.CLOCK, .RESET, .SLEEP,
    .GLOBAL_PULLUP_DISABLE, .WRITE, .PERIPH, .PIN_CHANGE_GROUP_EN,
    .PIN_CHANGE_MASK, .PAD_IN, .PAD_OUT, .PAD_OE, .PAD_PULLUP, .DIR_BIT,
    .OUT_BIT, .PIN_IN_BIT, .PIN_CHANGE_SRC, .TIMER_EXT_CLK_IN,
    .TIMER3_CAPTURE_IN);

// ==== port_alt_function_override_tb.sv ====
`timescale 1ns/1ps
module port_alt_function_override_tb;
    import pafo_pkg::*;
    logic         clock = 1'b0;
    logic         reset = 1'b1;
    logic         sleep = 1'b0;
    logic         pu_off = 1'b0;
    logic         grp   = 1'b0;
    pafo_write_t  wrt   = '0;
    pafo_periph_t per   = '0;
    logic [7:0]   mask = 8'h00, ext_en = 8'h00, ext_lvl = 8'h00;
    logic [7:0]   pad_in, pad_out, pad_oe, pad_pu, dir, outb, pin_in, pcs;
    logic         sel_in, sck_in, mi_in, si_in, tclk, tcap;
    int           fail_count = 0;
    int           compares = 0;
    int           cycles = 0;
    always #4 clock = ~clock;
    pafo_port i_dut (.CLOCK(clock), .RESET(reset), .SLEEP(sleep),
        .GLOBAL_PULLUP_DISABLE(pu_off), .WRITE(wrt), .PERIPH(per),
        .PIN_CHANGE_GROUP_EN(grp), .PIN_CHANGE_MASK(mask), .PAD_IN(pad_in),
        .PAD_OUT(pad_out), .PAD_OE(pad_oe), .PAD_PULLUP(pad_pu),
        .DIR_BIT(dir), .OUT_BIT(outb), .PIN_IN_BIT(pin_in),
        .PIN_CHANGE_SRC(pcs), .SPI_SLAVE_SEL_IN(sel_in), .SPI_CLK_IN(sck_in),
        .SPI_MASTER_IN(mi_in), .SPI_SLAVE_IN(si_in),
        .TIMER_EXT_CLK_IN(tclk), .TIMER3_CAPTURE_IN(tcap));
    pafo_pad_model i_pad (.clk(clock), .oe(pad_oe), .drive(pad_out),
        .pull_en(pad_pu), .ext_en(ext_en), .ext_lvl(ext_lvl), .pad(pad_in));
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk8
    // strobes {port, dir, pin} for one cycle
    task automatic wr(input logic [2:0] s, input logic [7:0] d);
        @(posedge clock);
        wrt <= {s, d};
        @(posedge clock);
        wrt <= '0;
        #1;
    endtask : wr
    task automatic t_gpio;
        chk8(dir, DIR_RESET);
        chk8(outb, OUT_RESET);
        wr(3'b010, 8'h0f);
        wr(3'b100, 8'h5a);
        chk8(pad_oe, 8'h0f);
        chk8(pad_out, 8'h0a);
        chk8(pad_pu, 8'h50);
        @(posedge clock);
        pu_off <= 1'b1;
        #1;
        chk8(pad_pu, 8'h00);
        @(posedge clock);
        pu_off <= 1'b0;
        #1;
        $display("gpio test done");
    endtask : t_gpio
    task automatic t_toggle;
        wr(3'b001, 8'hff);
        chk8(outb, 8'ha5);
        wr(3'b101, 8'h3c);
        chk8(outb, 8'h00);
        $display("toggle test done");
    endtask : t_toggle
    task automatic t_slave;
        wr(3'b010, 8'hff);
        wr(3'b100, 8'hff);
        @(posedge clock);
        per <= 7'b1000000;
        ext_en <= 8'h80;
        ext_lvl <= 8'h00;
        #1;
        chk8(pad_oe, 8'h57);
        chk8(pad_pu, 8'ha8);
        chk8(pad_out, 8'h47);
        chk8({7'h00, sel_in}, 8'h00);
        @(posedge clock);
        per <= 7'b1001000;
        #1;
        chk8(pad_out, 8'h57);
        $display("slave test done");
    endtask : t_slave
    task automatic t_master;
        @(posedge clock);
        per <= 7'b1100010;
        ext_en <= 8'h00;
        #1;
        chk8(pad_oe, 8'hef);
        chk8(pad_pu, 8'h10);
        chk8(pad_out, 8'hc5);
        @(posedge clock);
        per <= 7'b1110111;
        #1;
        chk8(pad_out, 8'hef);
        $display("master test done");
    endtask : t_master
    task automatic t_sleep;
        @(posedge clock);
        per <= '0;
        ext_en <= 8'hff;
        ext_lvl <= 8'ha5;
        wr(3'b010, 8'h00);
        wr(3'b100, 8'h00);
        repeat (5) @(posedge clock);
        #1;
        chk8(pin_in, 8'ha5);
        chk8(pcs, 8'ha5);
        chk8({2'b00, sel_in, sck_in, mi_in, si_in, tclk, tcap}, 8'h33);
        @(posedge clock);
        sleep <= 1'b1;
        #1;
        chk8(pcs, 8'h00);
        @(posedge clock);
        grp <= 1'b1;
        mask <= 8'h81;
        #1;
        chk8(pcs, 8'h81);
        $display("sleep test done");
    endtask : t_sleep
    task automatic wrap_up;
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : wrap_up
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            fail_count++;
            wrap_up;
        end
    end
    initial
    begin
        repeat (3) @(posedge clock);
        reset <= 1'b0;
        #1;
        t_gpio;
        t_toggle;
        t_slave;
        t_master;
        t_sleep;
        wrap_up;
    end
endmodule : port_alt_function_override_tb
